// ==== shared/vcc_pkg.sv ====
/*
  Package for the voltage comparator control block: register offsets,
  field positions, reset values and selection codes.
  Assumes an APB slave with 32-bit data and byte addresses.
*/
package vcc_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_ANALOG_ENABLE = 8'h00;
  localparam logic [7:0] OFS_COMP_CONTROL  = 8'h04;
  localparam logic [7:0] OFS_OSC_STATUS    = 8'h08;
  localparam logic [7:0] OFS_IRQ_CONTROL   = 8'h0C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_CMP_EN     = 7;
  localparam int BIT_RESULT     = 7;
  localparam int BIT_PIN_OE     = 6;
  localparam int BIT_IRQ_EN     = 0;
  localparam int BIT_CHANGE     = 1;
  localparam int BIT_GIE        = 2;
  localparam int PS_MSB         = 7;
  localparam int PS_LSB         = 4;
  localparam int VS_MSB         = 3;
  localparam int VS_LSB         = 0;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [3:0] VS_P2P      = 4'h0;
  localparam logic [3:0] PS_PAIR01   = 4'h0;
  localparam logic [3:0] PS_PAIR10   = 4'h1;
  localparam logic [3:0] PS_PAIR23   = 4'h2;
  localparam logic [3:0] PS_PAIR32   = 4'h3;

  // Analog source codes for the comparator input multiplexers
  typedef enum logic [2:0] {
    VCC_SRC_NONE,
    VCC_SRC_PAD0,
    VCC_SRC_PAD1,
    VCC_SRC_PAD2,
    VCC_SRC_PAD3,
    VCC_SRC_VREF
  } vcc_src_t;

endpackage

// ==== verilog/vcc_top.sv ====
/*
  Voltage comparator control: enable, mode and input routing, the
  change flag with its interrupt request, result polling and pin drive.
  Assumes an APB master on i_mclk and an analog comparator macro that
  returns its output on i_cmp_out, asynchronous to the clock.
  Assumes i_halt, i_first_pwm_channel_out and i_first_pwm_channel_oe come from logic on i_mclk.
  The analog macro decodes o_sel_noninv and o_sel_inv as vcc_src_t codes
  and builds its reference from o_vref_level in sixteenths of supply.
*/
`timescale 1ns/1ps
`default_nettype none

module vcc_top
  import vcc_pkg::*;
(
  input  wire logic        i_mclk,         // 40 MHz clock
  input  wire logic        i_srst,         // Sync reset, active high
  input  wire logic        i_psel,         // APB select
  input  wire logic        i_penable,      // APB enable
  input  wire logic        i_pwrite,       // APB write
  input  wire logic [7:0]  i_paddr,        // APB byte address
  input  wire logic [31:0] i_pwdata,       // APB write data
  output logic      [31:0] o_prdata,       // APB read data
  output logic             o_pready,       // APB ready
  output logic             o_pslverr,      // APB error
  input  wire logic        i_halt,         // Processor halt mode
  input  wire logic        i_cmp_out,      // Live comparator output
  input  wire logic        i_first_pwm_channel_out,     // First PWM channel level
  input  wire logic        i_first_pwm_channel_oe,      // First PWM channel enable
  output logic             o_cmp_power_en, // Comparator analog enable
  output logic      [2:0]  o_sel_noninv,   // Non-inverting source
  output logic      [2:0]  o_sel_inv,      // Inverting source
  output logic      [3:0]  o_vref_level,   // Reference in sixteenths
  output logic             o_pb3_out,      // Port B pin three level
  output logic             o_pb3_oe,       // Port B pin three drive
  output logic             o_cmp_irq_req,  // Comparator request
  output logic             o_cpu_irq       // Request gated by global enable
);

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  logic       cmp_en_q;
  logic [3:0] pad_sel_q;
  logic [3:0] ref_sel_q;
  logic       pin_oe_q;
  logic       irq_en_q;
  logic       change_q;
  logic       gie_q;
  logic       copy_q;
  logic       sync1_q;
  logic       sync2_q;
  logic       active;
  logic       wr_en;
  logic       rd_en;
  logic       hit;
  logic       mismatch;
  vcc_src_t   noninv_d;
  vcc_src_t   inv_d;
  // Decoded per-register strobes
  logic       wr_enable;
  logic       wr_control;
  logic       wr_status;
  logic       wr_irq;
  logic       rd_status;
  logic       flag_clr;

  // APB strobes
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;

  // Address decode
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_ANALOG_ENABLE) || (a == OFS_COMP_CONTROL) ||
             (a == OFS_OSC_STATUS) || (a == OFS_IRQ_CONTROL);
  endfunction

  // Single register match, shared by every strobe
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction

  assign hit       = mapped(i_paddr);
  // Zero wait state: every access ends in its first access cycle
  assign o_pready  = 1'b1;
  // Unmapped addresses answer with an error; writes there are dropped
  assign o_pslverr = i_psel && i_penable && !hit;

  // Per-register strobes, taken in the access phase
  assign wr_enable  = wr_en && is_reg(i_paddr, OFS_ANALOG_ENABLE);
  assign wr_control = wr_en && is_reg(i_paddr, OFS_COMP_CONTROL);
  assign wr_status  = wr_en && is_reg(i_paddr, OFS_OSC_STATUS);
  assign wr_irq     = wr_en && is_reg(i_paddr, OFS_IRQ_CONTROL);
  assign rd_status  = rd_en && is_reg(i_paddr, OFS_OSC_STATUS);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Both select fields are four bits, side by side in one byte
  if (PS_MSB != PS_LSB + 3 || VS_MSB != VS_LSB + 3 || PS_LSB != VS_MSB + 1) begin : g_fld
    $error("vcc_top: select fields must be adjacent four-bit fields");
  end
  // Enable, result and pin-enable bits sit inside the register byte
  if (BIT_CMP_EN > PS_MSB || BIT_RESULT > PS_MSB || BIT_PIN_OE > PS_MSB) begin : g_pos
    $error("vcc_top: field position outside the register byte");
  end
  // Result and pin enable share the status byte
  if (BIT_RESULT == BIT_PIN_OE) begin : g_sts
    $error("vcc_top: status fields overlap");
  end
  // Interrupt control bits must not overlap
  if (BIT_IRQ_EN == BIT_CHANGE || BIT_IRQ_EN == BIT_GIE || BIT_CHANGE == BIT_GIE) begin : g_irq
    $error("vcc_top: interrupt control fields overlap");
  end

  // ---------------------------------------------------------------
  // Comparator output synchroniser
  // ---------------------------------------------------------------
  // Comparator output is free running; two flops limit metastability
  // Latency: two edges to the status bit, three to the flag and pin
  // Two flops; only sync2_q feeds logic
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= i_cmp_out;
      sync2_q <= sync1_q;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  // enable bit reset
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cmp_en_q <= 1'b0;
    end else if (wr_enable) begin
      cmp_en_q <= i_pwdata[BIT_CMP_EN];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pad_sel_q <= RST_BYTE[PS_MSB:PS_LSB];
      ref_sel_q <= RST_BYTE[VS_MSB:VS_LSB];
    end else if (wr_control) begin
      pad_sel_q <= i_pwdata[PS_MSB:PS_LSB];
      ref_sel_q <= i_pwdata[VS_MSB:VS_LSB];
    end
  end

  // Pin output enable in status register
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pin_oe_q <= 1'b0;
    end else if (wr_status) begin
      pin_oe_q <= i_pwdata[BIT_PIN_OE];
    end
  end

  // Interrupt enable and global enable
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      irq_en_q <= 1'b0;
      gie_q    <= 1'b0;
    end else if (wr_irq) begin
      irq_en_q <= i_pwdata[BIT_IRQ_EN];
      gie_q    <= i_pwdata[BIT_GIE];
    end
  end

  // ---------------------------------------------------------------
  // Enable, routing
  // ---------------------------------------------------------------
  // Halt overrides the enable without touching the stored bit
  // halt forces off
  assign active = cmp_en_q && !i_halt;

  always_comb begin
    noninv_d = VCC_SRC_NONE;
    inv_d    = VCC_SRC_NONE;
    if (ref_sel_q != VS_P2P) begin
      inv_d = VCC_SRC_VREF;
      unique case (pad_sel_q)
        PS_PAIR01: noninv_d = VCC_SRC_PAD0;
        PS_PAIR10: noninv_d = VCC_SRC_PAD1;
        PS_PAIR23: noninv_d = VCC_SRC_PAD2;
        PS_PAIR32: noninv_d = VCC_SRC_PAD3;
        default:   noninv_d = VCC_SRC_NONE;
      endcase
    end else begin
      unique case (pad_sel_q)
        PS_PAIR01: begin
          noninv_d = VCC_SRC_PAD0;
          inv_d    = VCC_SRC_PAD1;
        end
        PS_PAIR10: begin
          noninv_d = VCC_SRC_PAD1;
          inv_d    = VCC_SRC_PAD0;
        end
        PS_PAIR23: begin
          noninv_d = VCC_SRC_PAD2;
          inv_d    = VCC_SRC_PAD3;
        end
        PS_PAIR32: begin
          noninv_d = VCC_SRC_PAD3;
          inv_d    = VCC_SRC_PAD2;
        end
        default: begin
          noninv_d = VCC_SRC_NONE;
          inv_d    = VCC_SRC_NONE;
        end
      endcase
    end
  end

  // Registered so the analog switches see one clean change per update
  // Registered analog control outputs
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_cmp_power_en <= 1'b0;
      o_sel_noninv   <= VCC_SRC_NONE;
      o_sel_inv      <= VCC_SRC_NONE;
      o_vref_level   <= RST_BYTE[VS_MSB:VS_LSB];
    end else begin
      o_cmp_power_en <= active;
      o_sel_noninv   <= noninv_d;
      o_sel_inv      <= inv_d;
      o_vref_level   <= ref_sel_q;
    end
  end

  // ---------------------------------------------------------------
  // Change detection
  // ---------------------------------------------------------------
  // Compare only while the comparator runs; a disabled or halted
  // comparator output means nothing and must not raise the flag
  assign mismatch = active && (sync2_q != copy_q);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      copy_q <= 1'b0;
    end else if (rd_status) begin
      copy_q <= sync2_q;
    end
  end

  assign flag_clr = wr_irq && !i_pwdata[BIT_CHANGE];

  // A change in the clear cycle wins, so no event is lost
  // set on mismatch, set wins
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      change_q <= 1'b0;
    end else if (mismatch) begin
      change_q <= 1'b1;
    end else if (flag_clr) begin
      change_q <= 1'b0;
    end
  end

  assign o_cmp_irq_req = active && irq_en_q && change_q;
  assign o_cpu_irq = o_cmp_irq_req && gie_q;

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // With pin_oe_q set, pin shows the synchronised output, three edges behind the pad; else the first PWM channel
  // synchronised output or PWM on pin
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_pb3_out <= 1'b0;
      o_pb3_oe  <= 1'b0;
    end else if (pin_oe_q) begin
      o_pb3_out <= sync2_q;
      o_pb3_oe  <= 1'b1;
    end else begin
      o_pb3_out <= i_first_pwm_channel_out;
      o_pb3_oe  <= i_first_pwm_channel_oe;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Loaded in the setup cycle so data stands through the access phase
  // result at bit seven
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= 32'h0000_0000;
      unique case (i_paddr)
        OFS_ANALOG_ENABLE: o_prdata[BIT_CMP_EN] <= cmp_en_q;
        OFS_COMP_CONTROL: begin
          o_prdata[PS_MSB:PS_LSB] <= pad_sel_q;
          o_prdata[VS_MSB:VS_LSB] <= ref_sel_q;
        end
        OFS_OSC_STATUS: begin
          o_prdata[BIT_RESULT] <= sync2_q;
          o_prdata[BIT_PIN_OE] <= pin_oe_q;
        end
        OFS_IRQ_CONTROL: begin
          o_prdata[BIT_IRQ_EN] <= irq_en_q;
          o_prdata[BIT_CHANGE] <= change_q;
          o_prdata[BIT_GIE]    <= gie_q;
        end
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== testbench/vcc_chk.sv ====
/* Checker for the vcc_top ports: halt, routing, request gating, pin and flag.
   Assumes vcc_pkg and is bound into every vcc_top. */
`timescale 1ns/1ps
`default_nettype none
module vcc_chk
  import vcc_pkg::*;
(
  input wire logic       i_mclk,         // Clock
  input wire logic       i_srst,         // Sync reset
  input wire logic       i_psel,         // APB select
  input wire logic       i_penable,      // APB enable
  input wire logic       i_pwrite,       // APB write
  input wire logic       i_halt,         // Halt mode
  input wire logic       i_cmp_out,      // Live output
  input wire logic       i_first_pwm_channel_oe,      // PWM enable
  input wire logic       o_cmp_power_en, // Analog enable
  input wire logic [2:0] o_sel_noninv,   // Non-inverting source
  input wire logic [2:0] o_sel_inv,      // Inverting source
  input wire logic [3:0] o_vref_level,   // Reference level
  input wire logic       o_pb3_out,      // Pin level
  input wire logic       o_pb3_oe,       // Pin drive
  input wire logic       o_cmp_irq_req,  // Request
  input wire logic       o_cpu_irq       // Gated request
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Bus write and the partner pad of a pair
  wire logic       apb_wr = i_psel && i_penable && i_pwrite;
  wire logic [2:0] pair_src = (o_sel_noninv == 3'(VCC_SRC_NONE)) ? o_sel_noninv :
                              o_sel_noninv[0] ? o_sel_noninv + 3'h1 : o_sel_noninv - 3'h1;
  // Output steady long enough to cross the sync path
  sequence s_cmp_steady;
    $stable(i_cmp_out) [*4];
  endsequence
  sequence s_pin_owned;
    o_pb3_oe && !$past(i_first_pwm_channel_oe);
  endsequence
  AST_HALT_OFF: assert property (i_halt |=> !o_cmp_power_en)
    else $error("comparator on in halt");
  AST_HALT_NO_IRQ: assert property (i_halt && $past(i_halt) |-> !o_cmp_irq_req)
    else $error("request while halted");
  AST_GIE_GATE: assert property (o_cpu_irq |-> o_cmp_irq_req)
    else $error("cpu request without source");
  AST_P2V_INV: assert property (o_vref_level != 4'h0 |-> o_sel_inv == 3'(VCC_SRC_VREF))
    else $error("reference not on inverting input");
  AST_REF_NONINV: assert property (o_sel_noninv != 3'(VCC_SRC_VREF))
    else $error("reference on non-inverting input");
  AST_P2P_PAIR: assert property (o_vref_level == 4'h0 |-> o_sel_inv == pair_src)
    else $error("pad pair wrong");
  AST_PIN_LIVE: assert property (s_cmp_steady ##0 s_pin_owned |-> o_pb3_out == i_cmp_out)
    else $error("pin not following output");
  AST_FLAG_HOLD: assert property (o_cmp_irq_req && !apb_wr && !$past(apb_wr)
    |=> o_cmp_irq_req || i_halt || $past(i_halt))
    else $error("flag dropped by itself");
endmodule
bind vcc_top vcc_chk u_chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_halt(i_halt), .i_cmp_out(i_cmp_out),
  .i_first_pwm_channel_oe(i_first_pwm_channel_oe), .o_cmp_power_en(o_cmp_power_en), .o_sel_noninv(o_sel_noninv),
  .o_sel_inv(o_sel_inv), .o_vref_level(o_vref_level), .o_pb3_out(o_pb3_out),
  .o_pb3_oe(o_pb3_oe), .o_cmp_irq_req(o_cmp_irq_req), .o_cpu_irq(o_cpu_irq));
`default_nettype wire

// ==== testbench/tb.sv ====
/* Self-checking bench for vcc_top: registers, routing sweep, flag, pin.
   Assumes vcc_pkg, the bound checker and a zero-wait APB slave. */
`timescale 1ns/1ps
`default_nettype none
module tb
  import vcc_pkg::*;
;
  logic        i_mclk = 1'b0, i_srst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_halt = 1'b0, i_cmp_out = 1'b0;
  logic        i_first_pwm_channel_out = 1'b0, i_first_pwm_channel_oe = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata;
  logic        o_pready, o_pslverr, o_cmp_power_en, o_pb3_out, o_pb3_oe;
  logic        o_cmp_irq_req, o_cpu_irq;
  logic [2:0]  o_sel_noninv, o_sel_inv;
  logic [3:0]  o_vref_level, vs;
  logic [33:0] q [$];
  logic [33:0] e;
  int          n_errors = 0, n_tests = 0, seed = 32'hE096;
  // Clock at 40 MHz
  always #12.5 i_mclk = ~i_mclk;
  vcc_top DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_halt(i_halt), .i_cmp_out(i_cmp_out),
    .i_first_pwm_channel_out(i_first_pwm_channel_out), .i_first_pwm_channel_oe(i_first_pwm_channel_oe), .o_cmp_power_en(o_cmp_power_en),
    .o_sel_noninv(o_sel_noninv), .o_sel_inv(o_sel_inv), .o_vref_level(o_vref_level),
    .o_pb3_out(o_pb3_out), .o_pb3_oe(o_pb3_oe), .o_cmp_irq_req(o_cmp_irq_req),
    .o_cpu_irq(o_cpu_irq));
  // Completed transfers against the oldest note
  always @(posedge i_mclk) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      e = q.pop_front();
      n_tests++;
      if (o_pslverr !== e[32] || (!e[33] && o_prdata !== e[31:0])) begin
        n_errors++;
        $display("BAD %0t apb %h err %b exp %h", $time, o_prdata, o_pslverr, e[31:0]);
      end
    end
  end
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; the note holds direction, error and read data
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x);
    int k;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    q.push_back({wr, a > OFS_IRQ_CONTROL, x});
    @(posedge i_mclk);
    i_penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_mclk);
      if (o_pready === 1'b1) break;
    end
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k == 20) begin
      n_errors++;
      $display("BAD %0t no ready", $time);
      wrap_up();
    end
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] x);
    n_tests++;
    if (got !== x) begin
      n_errors++;
      $display("BAD %0t pins %h exp %h", $time, got, x);
    end
    // Back on a rising edge before the next drive
    @(posedge i_mclk);
  endtask
  // Wait n edges, then sample settled outputs at the falling edge
  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  // Expected sources and level for a control value
  function automatic logic [10:0] route(input logic [3:0] ps, input logic [3:0] v);
    logic [2:0] p, n;
    p = (ps > 4'h3) ? 3'(VCC_SRC_NONE) : 3'(ps + 4'h1);
    if (v != 4'h0) n = 3'(VCC_SRC_VREF);
    else if (p == 3'(VCC_SRC_NONE)) n = p;
    else n = p[0] ? p + 3'h1 : p - 3'h1;
    return {p, n, v};
  endfunction
  // -----
  // Stimulus
  // -----
  initial begin
    repeat (20) @(posedge i_mclk);
    i_srst <= 1'b0;
    for (int i = 0; i < 5; i++) apb(1'b0, 8'(4 * i), 32'h0, 32'h0);
    wt(1);
    chk(o_cmp_power_en, 1'b0);
    apb(1'b1, OFS_ANALOG_ENABLE, 32'h80, 32'h0);
    wt(3);
    chk(o_cmp_power_en, 1'b1);
    i_halt <= 1'b1;
    wt(3);
    chk(o_cmp_power_en, 1'b0);
    i_halt <= 1'b0;
    for (int ps = 0; ps < 16; ps++) begin
      for (int m = 0; m < 2; m++) begin
        vs = m == 0 ? 4'h0 : ps == 0 ? 4'h1 : ps == 15 ? 4'hF : 4'(($random(seed) & 255) % 15 + 1);
        apb(1'b1, OFS_COMP_CONTROL, {24'h0, 4'(ps), vs}, 32'h0);
        apb(1'b0, OFS_COMP_CONTROL, 32'h0, {24'h0, 4'(ps), vs});
        wt(2);
        chk({o_sel_noninv, o_sel_inv, o_vref_level}, route(4'(ps), vs));
      end
    end
    apb(1'b1, OFS_IRQ_CONTROL, 32'h5, 32'h0);
    apb(1'b0, OFS_OSC_STATUS, 32'h0, 32'h0);
    apb(1'b1, OFS_IRQ_CONTROL, 32'h5, 32'h0);
    i_cmp_out <= 1'b1;
    wt(6);
    chk({o_cmp_irq_req, o_cpu_irq}, 2'b11);
    apb(1'b0, OFS_IRQ_CONTROL, 32'h0, 32'h7);
    apb(1'b0, OFS_OSC_STATUS, 32'h0, 32'h80);
    apb(1'b1, OFS_IRQ_CONTROL, 32'h1, 32'h0);
    wt(6);
    chk({o_cmp_irq_req, o_cpu_irq}, 2'b00);
    i_cmp_out <= 1'b0;
    wt(6);
    chk({o_cmp_irq_req, o_cpu_irq}, 2'b10);
    apb(1'b0, OFS_OSC_STATUS, 32'h0, 32'h0);
    i_halt <= 1'b1;
    wt(3);
    chk(o_cmp_irq_req, 1'b0);
    i_halt <= 1'b0;
    wt(3);
    chk(o_cmp_irq_req, 1'b1);
    apb(1'b1, OFS_IRQ_CONTROL, 32'h3, 32'h0);
    apb(1'b0, OFS_IRQ_CONTROL, 32'h0, 32'h3);
    apb(1'b1, OFS_ANALOG_ENABLE, 32'h0, 32'h0);
    wt(3);
    chk(o_cmp_irq_req, 1'b0);
    i_first_pwm_channel_oe <= 1'b1;
    i_first_pwm_channel_out <= 1'b1;
    apb(1'b1, OFS_OSC_STATUS, 32'h40, 32'h0);
    apb(1'b0, OFS_OSC_STATUS, 32'h0, 32'h40);
    wt(2);
    chk({o_pb3_oe, o_pb3_out}, 2'b10);
    i_cmp_out <= 1'b1;
    i_first_pwm_channel_out <= 1'b0;
    wt(5);
    chk({o_pb3_oe, o_pb3_out}, 2'b11);
    i_first_pwm_channel_oe <= 1'b0;
    wt(6);
    chk({o_pb3_oe, o_pb3_out}, 2'b11);
    i_first_pwm_channel_oe <= 1'b1;
    apb(1'b1, OFS_OSC_STATUS, 32'h0, 32'h0);
    wt(2);
    chk({o_pb3_oe, o_pb3_out}, 2'b10);
    i_first_pwm_channel_oe <= 1'b0;
    wt(2);
    chk(o_pb3_oe, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
